// ==== src/peripheral_irq_enable_bank3.sv ====
// enable bank 3: per-source interrupt masks, pending flags, apb access
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank3_regs.svh"

module peripheral_irq_enable_bank3 (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          ce,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [`IRQB3_ADDR_W-1:0]      paddr,
    input  wire logic [`IRQB3_DATA_W-1:0]      pwdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic [`IRQB3_DATA_W-1:0]           prdata,
    input  wire irq_bank3_pkg::irq_src_s       src,
    output logic                               irq
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    irq_bank3_pkg::bus_req_s  req;
    irq_bank3_pkg::reg8_t     rd_value;
    irq_bank3_pkg::reg8_t     flags;
    irq_bank3_pkg::reg8_t     mask_r;
    irq_bank3_pkg::reg8_t     mask_nxt;
    irq_bank3_pkg::reg8_t     pend_req;
    logic                     sel_enable;
    logic                     sel_pending;
    logic                     flag_clr;
    logic                     mask_wr;

    // every check below runs on pclk and sleeps through reset
    default clocking main_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------
    // bus front end
    // ------------------------------------------------------------------
    apb_port u_apb (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .rd_value (rd_value),
        .pready   (pready),
        .pslverr  (pslverr),
        .prdata   (prdata),
        .req      (req)
    );

    // register select from the live address
    assign sel_enable  = (req.addr == `IRQB3_ENABLE_OFFSET);
    assign sel_pending = (req.addr == `IRQB3_PENDING_OFFSET);
    assign mask_wr     = req.wr && sel_enable;

    // ------------------------------------------------------------------
    // mask register
    // ------------------------------------------------------------------
    // only implemented positions take write data, the rest stay zero
    always_comb begin
        mask_nxt = mask_r;
        if (req.wr && sel_enable) begin
            mask_nxt = req.wdata & `IRQB3_IMPL_MASK;
        end
    end

    // one reset for every source, power-on or otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= `IRQB3_ENABLE_RESET;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pending flags, cleared by reading the pending register
    // ------------------------------------------------------------------
    // the value captured for the read, normally in the setup cycle, is what gets cleared
    assign flag_clr = req.rd && sel_pending;

    pending_flags u_flags (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (ce),
        .src      (src),
        .clr_stb  (flag_clr),
        .clr_bits (prdata[`IRQB3_REG_W-1:0]),
        .flags    (flags)
    );

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    // unimplemented bits are forced low on every read path
    always_comb begin
        rd_value = 8'h00;
        if (sel_enable) begin
            rd_value = mask_r & `IRQB3_IMPL_MASK;
        end else if (sel_pending) begin
            rd_value = flags & `IRQB3_IMPL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // combined request
    // ------------------------------------------------------------------
    // the mask only gates forwarding; flags are set regardless of it
    assign pend_req = flags & mask_r;
    assign irq      = |pend_req;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    capcmp5_gate_a : assert property (@(posedge pclk) disable iff (!presetn)
        (flags[`IRQB3_CAPCMP5_BIT] && mask_r[`IRQB3_CAPCMP5_BIT]) |-> irq)
        else $error("enabled channel 5 flag did not raise irq");

    capcmp5_block_a : assert property (@(posedge pclk) disable iff (!presetn)
        (req.wr && sel_enable && !req.wdata[`IRQB3_CAPCMP5_BIT])
        |=> !mask_r[`IRQB3_CAPCMP5_BIT])
        else $error("channel 5 mask not cleared by write");

    capcmp4_write_a : assert property (@(posedge pclk) disable iff (!presetn)
        (req.wr && sel_enable)
        |=> (mask_r[`IRQB3_CAPCMP4_BIT] == $past(req.wdata[`IRQB3_CAPCMP4_BIT])))
        else $error("channel 4 mask did not take write data");

    capcmp3_gate_a : assert property (@(posedge pclk) disable iff (!presetn)
        (ce && src.capcmp3 && mask_r[`IRQB3_CAPCMP3_BIT] && !(req.wr && sel_enable))
        |=> irq)
        else $error("enabled channel 3 event did not raise irq next cycle");

    timer_six_a : assert property (@(posedge pclk) disable iff (!presetn)
        (req.wr && sel_enable && req.wdata[`IRQB3_TIMER_SIX_BIT])
        ##1 (!(req.wr && sel_enable)) [*2]
        |-> mask_r[`IRQB3_TIMER_SIX_BIT])
        else $error("timer six mask did not hold its written one");

    timer_four_a : assert property (@(posedge pclk) disable iff (!presetn)
        (flags == `IRQB3_IMPL_MASK && !mask_r[`IRQB3_TIMER_FOUR_BIT]
         && (mask_r & ~8'h02) == 8'h00) |-> !irq)
        else $error("masked timer four flag raised irq");

    reserved_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
        (ce && psel && penable && !pwrite)
        |-> (prdata[7] == 1'b0 && prdata[2] == 1'b0 && prdata[0] == 1'b0))
        else $error("unimplemented bit read as one");

    reset_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (mask_r == 8'h00 && !irq))
        else $error("mask not zero after reset");

    flag_ignores_mask_a : assert property (@(posedge pclk) disable iff (!presetn)
        (ce && src.capcmp5 && !mask_r[`IRQB3_CAPCMP5_BIT] && !mask_wr)
        |=> (flags[`IRQB3_CAPCMP5_BIT] && !pend_req[`IRQB3_CAPCMP5_BIT]))
        else $error("masked flag not set or wrongly forwarded");

    unused_bits_a : assert property (@(posedge pclk) disable iff (!presetn)
        (req.wr && sel_enable && req.wdata == 8'hff) |=> (mask_r == 8'h7a))
        else $error("write reached an unimplemented bit");

    read_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        (flag_clr && src == '0) |=> ((flags & $past(prdata[7:0])) == 8'h00))
        else $error("status read did not clear the flags it returned");

    // ------------------------------------------------------------------
    // per-bit checks: forwarding, mask writes, reserved bits, flags
    // ------------------------------------------------------------------
    // enabled channel 4 flag forwards
    capcmp4_gate_a : assert property (
        flags[`IRQB3_CAPCMP4_BIT] && mask_r[`IRQB3_CAPCMP4_BIT] |-> irq)
        else $error("channel 4 flag blocked");

    // enabled channel 3 flag forwards
    capcmp3_fwd_a : assert property (
        flags[`IRQB3_CAPCMP3_BIT] && mask_r[`IRQB3_CAPCMP3_BIT] |-> irq)
        else $error("channel 3 flag blocked");

    // enabled timer six flag forwards
    timer_six_gate_a : assert property (
        flags[`IRQB3_TIMER_SIX_BIT] && mask_r[`IRQB3_TIMER_SIX_BIT] |-> irq)
        else $error("timer six flag blocked");

    // enabled timer four flag forwards
    timer_four_gate_a : assert property (
        flags[`IRQB3_TIMER_FOUR_BIT] && mask_r[`IRQB3_TIMER_FOUR_BIT] |-> irq)
        else $error("timer four flag blocked");

    // all masks clear: flags may pend, nothing forwards
    all_masked_a : assert property (
        mask_r == 8'h00 |-> !irq)
        else $error("irq with every mask clear");

    // no pending flag, no request
    no_flags_a : assert property (
        flags == 8'h00 |-> !irq)
        else $error("irq with no flag pending");

    // channel 5 mask takes its write data
    capcmp5_write_a : assert property (
        mask_wr |=> mask_r[`IRQB3_CAPCMP5_BIT] == $past(req.wdata[`IRQB3_CAPCMP5_BIT]))
        else $error("channel 5 mask missed write");

    // channel 3 mask takes its write data
    capcmp3_write_a : assert property (
        mask_wr |=> mask_r[`IRQB3_CAPCMP3_BIT] == $past(req.wdata[`IRQB3_CAPCMP3_BIT]))
        else $error("channel 3 mask missed write");

    // timer six mask takes its write data
    timer_six_write_a : assert property (
        mask_wr |=> mask_r[`IRQB3_TIMER_SIX_BIT] == $past(req.wdata[`IRQB3_TIMER_SIX_BIT]))
        else $error("timer six mask missed write");

    // timer four mask takes its write data
    timer_four_write_a : assert property (
        mask_wr |=> mask_r[`IRQB3_TIMER_FOUR_BIT] == $past(req.wdata[`IRQB3_TIMER_FOUR_BIT]))
        else $error("timer four mask missed write");

    // a zero write clears channel 4's mask
    capcmp4_block_a : assert property (
        mask_wr && !req.wdata[`IRQB3_CAPCMP4_BIT] |=> !mask_r[`IRQB3_CAPCMP4_BIT])
        else $error("channel 4 mask not cleared");

    // a zero write clears channel 3's mask
    capcmp3_block_a : assert property (
        mask_wr && !req.wdata[`IRQB3_CAPCMP3_BIT] |=> !mask_r[`IRQB3_CAPCMP3_BIT])
        else $error("channel 3 mask not cleared");

    // a zero write clears timer six's mask
    timer_six_block_a : assert property (
        mask_wr && !req.wdata[`IRQB3_TIMER_SIX_BIT] |=> !mask_r[`IRQB3_TIMER_SIX_BIT])
        else $error("timer six mask not cleared");

    // a zero write clears timer four's mask
    timer_four_block_a : assert property (
        mask_wr && !req.wdata[`IRQB3_TIMER_FOUR_BIT] |=> !mask_r[`IRQB3_TIMER_FOUR_BIT])
        else $error("timer four mask not cleared");

    // pending writes, reads and a low ce leave the masks alone
    mask_keep_a : assert property (
        !mask_wr |=> mask_r == $past(mask_r))
        else $error("mask changed without a write");

    // reserved positions read zero whatever was written
    rd_reserved_a : assert property (
        (rd_value & ~`IRQB3_IMPL_MASK) == 8'h00)
        else $error("reserved bit in read value");

    // reserved mask positions never hold a one
    mask_reserved_a : assert property (
        (mask_r & ~`IRQB3_IMPL_MASK) == 8'h00)
        else $error("reserved mask bit set");

    // reserved flag positions never hold a one
    flags_reserved_a : assert property (
        (flags & ~`IRQB3_IMPL_MASK) == 8'h00)
        else $error("reserved flag bit set");

    // flags leave reset clear
    reset_flags_a : assert property (
        $rose(presetn) |-> flags == 8'h00)
        else $error("flags not zero after reset");

    // a pulse sets its flag whatever the mask
    capcmp4_sets_a : assert property (
        ce && src.capcmp4 |=> flags[`IRQB3_CAPCMP4_BIT])
        else $error("channel 4 pulse lost");

    // timer six pulse sets its flag
    timer_six_sets_a : assert property (
        ce && src.timer_six_match |=> flags[`IRQB3_TIMER_SIX_BIT])
        else $error("timer six pulse lost");

    // timer four pulse sets its flag
    timer_four_sets_a : assert property (
        ce && src.timer_four_match |=> flags[`IRQB3_TIMER_FOUR_BIT])
        else $error("timer four pulse lost");

    // a flag stays until a pending read takes it
    flag_sticky_a : assert property (
        flags[`IRQB3_CAPCMP5_BIT] && !flag_clr |=> flags[`IRQB3_CAPCMP5_BIT])
        else $error("channel 5 flag dropped");

endmodule

`default_nettype wire

// ==== src/irq_bank3_regs.svh ====
// register offsets, field positions and reset values of the enable bank
`ifndef IRQ_BANK3_REGS_SVH
`define IRQ_BANK3_REGS_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define IRQB3_ADDR_W          12
`define IRQB3_DATA_W          32
`define IRQB3_REG_W           8

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define IRQB3_ENABLE_OFFSET   12'h000
`define IRQB3_PENDING_OFFSET  12'h004

// ----------------------------------------------------------------------
// field positions, shared by the enable and pending registers
// ----------------------------------------------------------------------
`define IRQB3_CAPCMP5_BIT     6
`define IRQB3_CAPCMP4_BIT     5
`define IRQB3_CAPCMP3_BIT     4
`define IRQB3_TIMER_SIX_BIT   3
`define IRQB3_TIMER_FOUR_BIT  1

// ----------------------------------------------------------------------
// reset values and implemented-bit mask
// ----------------------------------------------------------------------
`define IRQB3_ENABLE_RESET    8'h00
`define IRQB3_PENDING_RESET   8'h00
`define IRQB3_IMPL_MASK       8'h7a

`endif

// ==== src/irq_bank3_pkg.sv ====
// types and layout helpers shared by the enable bank files
`include "irq_bank3_regs.svh"

package irq_bank3_pkg;

    typedef logic [`IRQB3_REG_W-1:0] reg8_t;

    // one pulse per peripheral condition
    typedef struct packed {
        logic capcmp5;
        logic capcmp4;
        logic capcmp3;
        logic timer_six_match;
        logic timer_four_match;
    } irq_src_s;

    // a completed register access, as seen by the register file
    typedef struct packed {
        logic                      wr;
        logic                      rd;
        logic [`IRQB3_ADDR_W-1:0]  addr;
        reg8_t                     wdata;
    } bus_req_s;

    // place the source pulses at their register bit positions
    function automatic reg8_t src_to_layout(input irq_src_s s);
        reg8_t v;
        v = 8'h00;
        v[`IRQB3_CAPCMP5_BIT]    = s.capcmp5;
        v[`IRQB3_CAPCMP4_BIT]    = s.capcmp4;
        v[`IRQB3_CAPCMP3_BIT]    = s.capcmp3;
        v[`IRQB3_TIMER_SIX_BIT]  = s.timer_six_match;
        v[`IRQB3_TIMER_FOUR_BIT] = s.timer_four_match;
        return v;
    endfunction

endpackage

// ==== src/apb_port.sv ====
// apb slave front end: decode, read data capture, access strobes
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank3_regs.svh"

module apb_port (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          ce,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [`IRQB3_ADDR_W-1:0]      paddr,
    input  wire logic [`IRQB3_DATA_W-1:0]      pwdata,
    input  wire irq_bank3_pkg::reg8_t          rd_value,
    output logic                               pready,
    output logic                               pslverr,
    output logic [`IRQB3_DATA_W-1:0]           prdata,
    output irq_bank3_pkg::bus_req_s            req
);

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [`IRQB3_ADDR_W-1:0] a);
        return (a == `IRQB3_ENABLE_OFFSET) || (a == `IRQB3_PENDING_OFFSET);
    endfunction

    logic                      hit;
    logic                      access;
    logic                      done;
    logic                      held_r;
    logic                      held_nxt;
    logic [`IRQB3_DATA_W-1:0]  prdata_r;
    logic [`IRQB3_DATA_W-1:0]  prdata_nxt;

    // no wait states normally; a read whose setup cycle was frozen by ce
    // waits one cycle, so its answer still comes from a flop
    assign hit     = addr_hit(paddr);
    assign access  = ce && psel && penable;
    assign pready  = ce && !(psel && penable && !pwrite && !held_r);
    assign done    = access && pready;
    assign pslverr = access && !hit;
    assign prdata  = prdata_r;

    // strobes fire only at the completing edge of the access phase
    always_comb begin
        req.wr    = done && pwrite && hit;
        req.rd    = done && !pwrite && hit;
        req.addr  = paddr;
        req.wdata = pwdata[`IRQB3_REG_W-1:0];
    end

    // read data is taken once per read, normally in the setup cycle
    always_comb begin
        prdata_nxt = prdata_r;
        held_nxt   = held_r;
        if (ce && psel && !pwrite && !held_r) begin
            prdata_nxt = {24'h000000, (hit ? rd_value : 8'h00)};
            held_nxt   = 1'b1;
        end else if (done) begin
            held_nxt   = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
            held_r   <= 1'b0;
        end else begin
            prdata_r <= prdata_nxt;
            held_r   <= held_nxt;
        end
    end

    unmapped_err_a : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && ce && !addr_hit(paddr)) |-> (pslverr && !req.wr && !req.rd))
        else $error("unmapped access not refused");

endmodule

`default_nettype wire

// ==== src/pending_flags.sv ====
// sticky pending flags, set by peripheral pulses, cleared by a status read
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank3_regs.svh"

module pending_flags (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          ce,
    input  wire irq_bank3_pkg::irq_src_s       src,
    input  wire logic                          clr_stb,
    input  wire irq_bank3_pkg::reg8_t          clr_bits,
    output irq_bank3_pkg::reg8_t               flags
);

    irq_bank3_pkg::reg8_t  flags_r;
    irq_bank3_pkg::reg8_t  flags_nxt;
    irq_bank3_pkg::reg8_t  set_v;
    irq_bank3_pkg::reg8_t  clr_v;

    // set wins over clear; only the bits software actually saw are cleared,
    // so a pulse between the setup and access cycles is not lost
    always_comb begin
        set_v     = irq_bank3_pkg::src_to_layout(src);
        clr_v     = clr_stb ? clr_bits : 8'h00;
        flags_nxt = flags_r;
        if (ce) begin
            flags_nxt = ((flags_r & ~clr_v) | set_v) & `IRQB3_IMPL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_r <= `IRQB3_PENDING_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;

    flag_sets_a : assert property (@(posedge pclk) disable iff (!presetn)
        (ce && src.capcmp3) |=> flags_r[`IRQB3_CAPCMP3_BIT])
        else $error("source pulse did not set its pending flag");

    set_beats_clear_a : assert property (@(posedge pclk) disable iff (!presetn)
        (ce && clr_stb && src.timer_four_match) |=> flags_r[`IRQB3_TIMER_FOUR_BIT])
        else $error("clear overrode a simultaneous set");

endmodule

`default_nettype wire

// ==== test/peripheral_irq_enable_bank3_tb_top.sv ====
// self-checking bench for the interrupt enable bank
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank3_regs.svh"

module peripheral_irq_enable_bank3_tb_top;
    // ------------------------------------------------------------------
    // signals and bench state
    // ------------------------------------------------------------------
    localparam logic [11:0] en_addr  = `IRQB3_ENABLE_OFFSET;
    localparam logic [11:0] pnd_addr = `IRQB3_PENDING_OFFSET;
    localparam logic [7:0]  impl     = 8'h7a;  // bits 6,5,4,3,1 exist

    logic                       pclk;
    logic                       presetn;
    logic                       ce;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [11:0]                paddr;
    logic [31:0]                pwdata;
    logic                       pready;
    logic                       pslverr;
    logic [31:0]                prdata;
    irq_bank3_pkg::irq_src_s    src;
    logic                       irq;
    int                         fail_count;
    int                         samples_checked;
    logic [31:0]                seed;
    logic [7:0]                 en_exp;
    logic [7:0]                 pnd_exp;

    peripheral_irq_enable_bank3 dut (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pready  (pready),
        .pslverr (pslverr),
        .prdata  (prdata),
        .src     (src),
        .irq     (irq)
    );

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // expectation helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // source order is capcmp5..timer_four, msb first
    function automatic logic [7:0] map_src(input logic [4:0] s);
        return {1'b0, s[4], s[3], s[2], s[1], 1'b0, s[0], 1'b0};
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask

    // ------------------------------------------------------------------
    // apb master: waits on pready, never assumes a latency
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            fail_count++;
            $display("Error pready timeout");
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        if (a == en_addr) en_exp = d[7:0] & impl;
    endtask

    // a pending read clears exactly the bits it returned
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check_word(what, exp, r);
        if (a == pnd_addr) pnd_exp = pnd_exp & ~exp[7:0];
    endtask

    // one-cycle source pulse, irq judged once the flags have landed
    task automatic pulse(input logic [4:0] s);
        @(posedge pclk);
        src <= irq_bank3_pkg::irq_src_s'(s);
        @(posedge pclk);
        src <= '0;
        pnd_exp = pnd_exp | map_src(s);
        @(negedge pclk);
        check_bit("irq", |(pnd_exp & en_exp), irq);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        int          i;
        logic [4:0]  oh;
        logic [31:0] d;
        logic        e;
        pclk = 1'b0;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        src = '0;
        fail_count = 0;
        samples_checked = 0;
        seed = 32'h3a73;
        en_exp = 8'h00;
        pnd_exp = 8'h00;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(en_addr, 32'h0, "enable after reset");
        rd_chk(pnd_addr, 32'h0, "pending after reset");
        // each mask alone: masked flag still sets, only its own source fires
        for (i = 0; i < 5; i++) begin
            oh = 5'(1 << i);
            wr_reg(en_addr, 32'h0);
            pulse(oh);
            rd_chk(pnd_addr, {24'h0, map_src(oh)}, "masked flag");
            wr_reg(en_addr, {24'h0, map_src(oh)});
            pulse(~oh);
            pulse(oh);
            rd_chk(pnd_addr, {24'h0, impl}, "all flags");
            @(negedge pclk);
            check_bit("irq after clear", 1'b0, irq);
        end
        // corner patterns on the reserved bits
        for (i = 0; i < 3; i++) begin
            wr_reg(en_addr, (i == 0) ? 32'hffffffff : (i == 1) ? 32'h00000085 : 32'h0);
            rd_chk(en_addr, {24'h0, en_exp}, "enable corner");
        end
        // random masks and source pulses
        for (i = 0; i < 40; i++) begin
            seed = xorshift(seed);
            wr_reg(en_addr, seed);
            rd_chk(en_addr, {24'h0, seed[7:0] & impl}, "enable readback");
            seed = xorshift(seed);
            pulse(seed[4:0]);
            if (seed[8]) rd_chk(pnd_addr, {24'h0, pnd_exp}, "pending");
        end
        // unmapped places refuse, pending ignores writes
        wr_reg(en_addr, 32'h7a);
        seed = xorshift(seed);
        apb(1'b1, {seed[11:4], 4'h8}, 32'hffffffff, d, e);
        check_bit("pslverr write", 1'b1, e);
        apb(1'b0, 12'hffc, 32'h0, d, e);
        check_bit("pslverr read", 1'b1, e);
        check_word("unmapped read", 32'h0, d);
        wr_reg(pnd_addr, 32'hff);
        rd_chk(en_addr, 32'h7a, "enable kept");
        rd_chk(pnd_addr, {24'h0, pnd_exp}, "pending kept");
        // clock enable low stalls the access
        @(posedge pclk);
        ce <= 1'b0;
        fork
            wr_reg(en_addr, 32'h10);
            begin
                repeat (3) @(posedge pclk);
                check_bit("pready stalled", 1'b0, pready);
                ce <= 1'b1;
            end
        join
        rd_chk(en_addr, 32'h10, "enable after stall");
        // a read whose setup cycle is frozen must not return stale data
        @(posedge pclk);
        ce <= 1'b0;
        fork
            rd_chk(pnd_addr, {24'h0, pnd_exp}, "pending after stall");
            begin
                repeat (3) @(posedge pclk);
                ce <= 1'b1;
            end
        join
        // second reset in mid-run with a request pending
        pulse(5'h1f);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        en_exp = 8'h00;
        pnd_exp = 8'h00;
        @(negedge pclk);
        check_bit("irq after reset", 1'b0, irq);
        rd_chk(en_addr, 32'h0, "enable mid reset");
        finish_test();
    end
endmodule

`default_nettype wire
